// >>> dual_timer.sv
// Two 8/13/16-bit counter/timers with byte register access
module dual_timer
	import timer_pkg::*;
(
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// Register port
	input wire logic [7:0] reg_addr,
	input wire logic reg_wr,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	// Vector acknowledges
	input wire logic timer_a_vector_ack,
	input wire logic timer_b_vector_ack,
	// External pins
	input wire logic timer_a_count_pin,
	input wire logic timer_b_count_pin,
	input wire logic first_ext_interrupt_line,
	input wire logic second_ext_interrupt_line,
	input wire logic ext_prescale_clk,
	// Status out
	output logic timer_a_overflow_flag,
	output logic timer_b_overflow_flag,
	output logic timer_b_overflow_pulse
);
	logic [7:0] timer_mode_reg, clock_control_reg, ext_interrupt_config_reg;
	logic timer_a_run_bit, timer_b_run_bit;
	logic [7:0] timer_a_low_byte, timer_a_high_byte;
	logic [7:0] timer_b_low_byte, timer_b_high_byte;
	logic [1:0] sync_a, sync_b, sync_g1, sync_g2, sync_ext;
	logic last_a, last_b, last_ext;
	logic pre_tick;
	logic [1:0] mode_a, mode_b;
	logic split;
	logic en_a, en_b, en_ah;
	logic inc_a, inc_b, inc_ah;
	logic gate_a_ok, gate_b_ok;
	logic ovf_a, ovf_b, ovf_ah;
	logic [7:0] next_al, next_ah, next_bl, next_bh;

	function automatic logic wr_hit(input logic [7:0] a, input logic [7:0] t);
		return reg_wr && (a == t);
	endfunction

	// ----------------------------------------
	// Input synchronisers
	// ----------------------------------------
	// Two-stage only; edge detect reads the second stage
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			sync_a <= 2'h0;
			sync_b <= 2'h0;
			sync_g1 <= 2'h0;
			sync_g2 <= 2'h0;
			sync_ext <= 2'h0;
			last_a <= 1'b0;
			last_b <= 1'b0;
			last_ext <= 1'b0;
		end else begin
			sync_a <= {sync_a[0], timer_a_count_pin};
			sync_b <= {sync_b[0], timer_b_count_pin};
			sync_g1 <= {sync_g1[0], first_ext_interrupt_line};
			sync_g2 <= {sync_g2[0], second_ext_interrupt_line};
			sync_ext <= {sync_ext[0], ext_prescale_clk};
			last_a <= sync_a[1];
			last_b <= sync_b[1];
			last_ext <= sync_ext[1];
		end
	end

	prescaler u_prescaler (
		.ref_clk(ref_clk),
		.rst(rst),
		.prescale_field(clock_control_reg[PRESCALE_LSB +: 2]),
		.ext_clk_edge(sync_ext[1] && !last_ext),
		.tick(pre_tick)
	);

	// ----------------------------------------
	// Enables
	// ----------------------------------------
	always_comb begin
		mode_a = timer_mode_reg[MODE_A_LSB + MODE_FIELD_LSB +: 2];
		mode_b = timer_mode_reg[MODE_B_LSB + MODE_FIELD_LSB +: 2];
		split = (mode_a == MODE_SPLIT);
		gate_a_ok = !timer_mode_reg[MODE_A_LSB + MODE_GATE]
			|| (sync_g1[1] == ext_interrupt_config_reg[FIRST_LINE_POLARITY]);
		gate_b_ok = !timer_mode_reg[MODE_B_LSB + MODE_GATE]
			|| (sync_g2[1] == ext_interrupt_config_reg[SECOND_LINE_POLARITY]);
		en_a = timer_a_run_bit && gate_a_ok;
		en_b = split ? (mode_b != MODE_SPLIT)
			: (timer_b_run_bit && gate_b_ok && mode_b != MODE_SPLIT);
		en_ah = timer_b_run_bit;
		// Falling edge on synchronised pin
		if (timer_mode_reg[MODE_A_LSB + MODE_COUNT_SEL])
			inc_a = en_a && last_a && !sync_a[1];
		else
			inc_a = en_a && (clock_control_reg[CLK_A_SELECT] || pre_tick);
		if (timer_mode_reg[MODE_B_LSB + MODE_COUNT_SEL] && !split)
			inc_b = en_b && last_b && !sync_b[1];
		else
			inc_b = en_b && (clock_control_reg[CLK_B_SELECT] || pre_tick);
		inc_ah = en_ah && (clock_control_reg[CLK_A_SELECT] || pre_tick);
	end

	// ----------------------------------------
	// Counter arithmetic
	// ----------------------------------------
	always_comb begin
		next_al = timer_a_low_byte;
		next_ah = timer_a_high_byte;
		ovf_a = 1'b0;
		ovf_ah = 1'b0;
		if (inc_a) begin
			case (mode_a)
				MODE_13BIT: begin
					next_al = {3'h0, timer_a_low_byte[4:0] + 5'h01};
					if (timer_a_low_byte[4:0] == LOW5_MAX) begin
						next_ah = timer_a_high_byte + 8'h01;
						ovf_a = (timer_a_high_byte == BYTE_MAX);
					end
				end
				MODE_16BIT: begin
					{next_ah, next_al} = {timer_a_high_byte, timer_a_low_byte}
						+ 16'h0001;
					ovf_a = ({timer_a_high_byte, timer_a_low_byte} == 16'hFFFF);
				end
				MODE_RELOAD8: begin
					ovf_a = (timer_a_low_byte == BYTE_MAX);
					next_al = ovf_a ? timer_a_high_byte : timer_a_low_byte + 8'h01;
				end
				default: begin
					next_al = timer_a_low_byte + 8'h01;
					ovf_a = (timer_a_low_byte == BYTE_MAX);
				end
			endcase
		end
		if (split && inc_ah) begin
			next_ah = timer_a_high_byte + 8'h01;
			ovf_ah = (timer_a_high_byte == BYTE_MAX);
		end
	end

	always_comb begin
		next_bl = timer_b_low_byte;
		next_bh = timer_b_high_byte;
		ovf_b = 1'b0;
		if (inc_b) begin
			case (mode_b)
				MODE_13BIT: begin
					next_bl = {3'h0, timer_b_low_byte[4:0] + 5'h01};
					if (timer_b_low_byte[4:0] == LOW5_MAX) begin
						next_bh = timer_b_high_byte + 8'h01;
						ovf_b = (timer_b_high_byte == BYTE_MAX);
					end
				end
				MODE_16BIT: begin
					{next_bh, next_bl} = {timer_b_high_byte, timer_b_low_byte}
						+ 16'h0001;
					ovf_b = ({timer_b_high_byte, timer_b_low_byte} == 16'hFFFF);
				end
				MODE_RELOAD8: begin
					ovf_b = (timer_b_low_byte == BYTE_MAX);
					next_bl = ovf_b ? timer_b_high_byte : timer_b_low_byte + 8'h01;
				end
				default: begin
					next_bl = timer_b_low_byte;
				end
			endcase
		end
	end

	// ----------------------------------------
	// Count registers
	// ----------------------------------------
	// Software write wins so a reload value lands exactly as written
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			timer_a_low_byte <= RESET_BYTE;
			timer_a_high_byte <= RESET_BYTE;
			timer_b_low_byte <= RESET_BYTE;
			timer_b_high_byte <= RESET_BYTE;
		end else begin
			timer_a_low_byte <= wr_hit(reg_addr, ADDR_TIMER_A_LOW_BYTE)
				? reg_wdata : next_al;
			timer_a_high_byte <= wr_hit(reg_addr, ADDR_TIMER_A_HIGH_BYTE)
				? reg_wdata : next_ah;
			timer_b_low_byte <= wr_hit(reg_addr, ADDR_TIMER_B_LOW_BYTE)
				? reg_wdata : next_bl;
			timer_b_high_byte <= wr_hit(reg_addr, ADDR_TIMER_B_HIGH_BYTE)
				? reg_wdata : next_bh;
		end
	end

	// ----------------------------------------
	// Configuration and control
	// ----------------------------------------
	// Run bit writes leave the count alone
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			timer_mode_reg <= RESET_BYTE;
			clock_control_reg <= RESET_BYTE;
			ext_interrupt_config_reg <= RESET_BYTE;
			timer_a_run_bit <= 1'b0;
			timer_b_run_bit <= 1'b0;
		end else begin
			if (wr_hit(reg_addr, ADDR_TIMER_MODE_REG))
				timer_mode_reg <= reg_wdata;
			if (wr_hit(reg_addr, ADDR_CLOCK_CONTROL_REG))
				clock_control_reg <= reg_wdata;
			if (wr_hit(reg_addr, ADDR_EXT_INTERRUPT_CONFIG_REG))
				ext_interrupt_config_reg <= reg_wdata;
			if (wr_hit(reg_addr, ADDR_TIMER_CONTROL_STATUS)) begin
				timer_a_run_bit <= reg_wdata[TCS_A_RUN];
				timer_b_run_bit <= reg_wdata[TCS_B_RUN];
			end
		end
	end

	// ----------------------------------------
	// Overflow flags
	// ----------------------------------------
	// Hardware set beats a same-cycle clear
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			timer_a_overflow_flag <= 1'b0;
			timer_b_overflow_flag <= 1'b0;
			timer_b_overflow_pulse <= 1'b0;
		end else begin
			if (ovf_a)
				timer_a_overflow_flag <= 1'b1;
			else if (timer_a_vector_ack)
				timer_a_overflow_flag <= 1'b0;
			else if (wr_hit(reg_addr, ADDR_TIMER_CONTROL_STATUS))
				timer_a_overflow_flag <= reg_wdata[TCS_A_OVERFLOW];
			if (split ? ovf_ah : ovf_b)
				timer_b_overflow_flag <= 1'b1;
			else if (timer_b_vector_ack)
				timer_b_overflow_flag <= 1'b0;
			else if (wr_hit(reg_addr, ADDR_TIMER_CONTROL_STATUS))
				timer_b_overflow_flag <= reg_wdata[TCS_B_OVERFLOW];
			timer_b_overflow_pulse <= ovf_b;
		end
	end

	// ----------------------------------------
	// Read-back
	// ----------------------------------------
	// Low byte reads back unmasked; 13-bit counting clears its top bits
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			reg_rdata <= RESET_BYTE;
		end else if (reg_addr == ADDR_TIMER_CONTROL_STATUS) begin
			reg_rdata <= {timer_b_overflow_flag, timer_b_run_bit,
				timer_a_overflow_flag, timer_a_run_bit, 4'h0};
		end else if (reg_addr == ADDR_TIMER_MODE_REG) begin
			reg_rdata <= timer_mode_reg;
		end else if (reg_addr == ADDR_TIMER_A_LOW_BYTE) begin
			reg_rdata <= timer_a_low_byte;
		end else if (reg_addr == ADDR_TIMER_B_LOW_BYTE) begin
			reg_rdata <= timer_b_low_byte;
		end else if (reg_addr == ADDR_TIMER_A_HIGH_BYTE) begin
			reg_rdata <= timer_a_high_byte;
		end else if (reg_addr == ADDR_TIMER_B_HIGH_BYTE) begin
			reg_rdata <= timer_b_high_byte;
		end else if (reg_addr == ADDR_CLOCK_CONTROL_REG) begin
			reg_rdata <= clock_control_reg;
		end else if (reg_addr == ADDR_EXT_INTERRUPT_CONFIG_REG) begin
			reg_rdata <= ext_interrupt_config_reg;
		end else begin
			reg_rdata <= RESET_BYTE;
		end
	end
endmodule // dual_timer

// >>> dual_timer_counter_modes_test.sv
// Self-checking bench for the dual counter/timer
module dual_timer_counter_modes_test
	import timer_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	localparam CTL = ADDR_TIMER_CONTROL_STATUS;
	localparam MOD = ADDR_TIMER_MODE_REG;
	localparam CLK = ADDR_CLOCK_CONTROL_REG;
	localparam ALO = ADDR_TIMER_A_LOW_BYTE;
	localparam AHI = ADDR_TIMER_A_HIGH_BYTE;
	localparam BLO = ADDR_TIMER_B_LOW_BYTE;
	logic ref_clk, rst, reg_wr, ack_a, ack_b, rd_v, rd_seen;
	logic flag_a, flag_b, pulse_b, ext_clk;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, lo, hi, got;
	logic [1:0] pin, gate;
	logic [23:0] exp_q[$];
	logic [23:0] e;
	int n_fail, checks, pulses, n, dv[4];
	dual_timer dut (.ref_clk, .rst, .reg_addr, .reg_wr, .reg_wdata,
		.reg_rdata, .timer_a_vector_ack(ack_a), .timer_b_vector_ack(ack_b),
		.timer_a_count_pin(pin[0]), .timer_b_count_pin(pin[1]),
		.first_ext_interrupt_line(gate[0]),
		.second_ext_interrupt_line(gate[1]), .ext_prescale_clk(ext_clk),
		.timer_a_overflow_flag(flag_a), .timer_b_overflow_flag(flag_b),
		.timer_b_overflow_pulse(pulse_b));
	pins_model pm (.ref_clk, .count_pin(pin), .gate_line(gate), .ext_clk);
	// ----
	// Drivers and checks
	// ----
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		#1 reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(posedge ref_clk);
		#1 reg_wr = 1'b0;
	endtask
	// Expectation is a masked range: {mask, low, high}
	task automatic rd(input logic [7:0] a, m, l, h);
		@(posedge ref_clk);
		#1 reg_addr = a;
		rd_v = 1'b1;
		exp_q.push_back({m, l, h});
		@(posedge ref_clk);
		#1 rd_v = 1'b0;
	endtask
	task automatic chk(input logic ok);
		checks++;
		if (ok !== 1'b1) begin
			n_fail++;
			$display("unexpected %0t output state", $time);
		end
	endtask
	task automatic run(input logic [7:0] c, input int t, input logic [1:0] f);
		wr(CTL, c);
		repeat (t) @(posedge ref_clk);
		#1 chk({flag_b, flag_a} === f);
		wr(CTL, 8'h00);
	endtask
	task automatic stop_test;
		if (n_fail == 0 && checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end
	always @(posedge ref_clk) rd_seen <= rd_v;
	always @(posedge ref_clk) if (pulse_b === 1'b1) pulses++;
	always @(negedge ref_clk) begin
		if (rd_seen === 1'b1) begin
			e = exp_q.pop_front();
			got = reg_rdata & e[23:16];
			checks++;
			if ((got inside {[e[15:8]:e[7:0]]}) !== 1'b1) begin
				n_fail++;
				$display("unexpected %0t read %h", $time, reg_rdata);
			end
		end
	end
	// Whole run needs well under this
	initial begin
		#200000;
		n_fail++;
		stop_test();
	end
	// ----
	// Scenarios
	// ----
	initial begin
		rst = 1'b1;
		{reg_wr, ack_a, ack_b, rd_v, rd_seen} = 5'h00;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		{n_fail, checks, pulses} = 0;
		dv = '{DIV12, DIV4, DIV48, DIV_EXT * 4};
		void'($urandom(32'h2D8649AB));
		repeat (16) @(posedge ref_clk);
		#1 rst = 1'b0;
		rd(CTL, 8'hFF, 8'h00, 8'h00);
		rd(8'h00, 8'hFF, 8'h00, 8'h00);
		wr(CLK, 8'h0C);
		for (int m = 0; m < 2; m++) begin
			wr(MOD, 8'(m));
			wr(AHI, 8'hFF);
			wr(ALO, 8'h1F);
			run(8'h10, 4, {1'b0, m == 0});
			run(8'h10, 4, 2'h0);
			hi = m ? 8'hFF : 8'h00;
			rd(AHI, 8'hFF, hi, hi);
			lo = m ? 8'h28 : 8'h08;
			rd(ALO, m ? 8'hFF : 8'h1F, lo, lo + 8'h08);
		end
		wr(MOD, 8'h02);
		wr(AHI, 8'hF0);
		wr(ALO, 8'hFE);
		run(8'h10, 4, 2'h1);
		rd(AHI, 8'hFF, 8'hF0, 8'hF0);
		rd(ALO, 8'hFF, 8'hF1, 8'hF8);
		wr(MOD, 8'h01);
		for (int p = 0; p < 4; p++) begin
			wr(CLK, 8'(p));
			wr(ALO, 8'h00);
			run(8'h10, 240, 2'h0);
			lo = 8'(240 / dv[p]);
			rd(ALO, 8'hFF, lo, lo + 8'h02);
		end
		for (int t = 0; t < 2; t++) begin
			// B counts in 13-bit mode so that mode is seen on both timers
			wr(MOD, (8'h0D - 8'(t)) << (4 * t));
			for (int g = 0; g < 3; g++) begin
				wr(ADDR_EXT_INTERRUPT_CONFIG_REG, 8'(g < 2) << (4 * t + 3));
				pm.gate(t, g == 1);
				wr(t ? BLO : ALO, 8'h00);
				n = 1 + $urandom % 15;
				wr(CTL, 8'h10 << (2 * t));
				pm.pulse(t, n);
				wr(CTL, 8'h00);
				lo = (g == 0) ? 8'h00 : 8'(n);
				rd(t ? BLO : ALO, 8'hFF, lo, lo);
			end
		end
		wr(CLK, 8'h0C);
		wr(MOD, 8'h20);
		wr(ADDR_TIMER_B_HIGH_BYTE, 8'hFF);
		wr(BLO, 8'hFF);
		run(8'h40, 4, 2'h2);
		// Stop edge overflow keeps the flag, so clear it before split
		wr(CTL, 8'h00);
		chk({flag_b, flag_a} === 2'h0);
		// Split: A low on A run, A high on B run, B parked
		wr(MOD, 8'h33);
		wr(AHI, 8'hFE);
		wr(ALO, 8'hFE);
		wr(BLO, 8'h55);
		run(8'h50, 4, 2'h3);
		rd(AHI, 8'hFF, 8'h02, 8'h08);
		rd(ALO, 8'hFF, 8'h02, 8'h08);
		rd(BLO, 8'hFF, 8'h55, 8'h55);
		wr(MOD, 8'h23);
		wr(BLO, 8'hFF);
		pulses = 0;
		run(8'h00, 8, 2'h0);
		chk(pulses > 0);
		// Write lands over the running reload timer
		wr(BLO, 8'h00);
		rd(BLO, 8'hFF, 8'h01, 8'h04);
		wr(MOD, 8'h33);
		wr(CTL, 8'hA0);
		rd(CTL, 8'hFF, 8'hA0, 8'hA0);
		@(posedge ref_clk);
		#1 {ack_a, ack_b} = 2'h3;
		@(posedge ref_clk);
		#1 {ack_a, ack_b} = 2'h0;
		chk({flag_b, flag_a} === 2'h0);
		// Mid-run reset returns the mode register to zero
		rst = 1'b1;
		@(posedge ref_clk);
		#1 rst = 1'b0;
		rd(MOD, 8'hFF, 8'h00, 8'h00);
		// Let the read compare run before the verdict
		@(posedge ref_clk);
		stop_test();
	end
endmodule // dual_timer_counter_modes_test

// >>> dual_timer_sva.sv
// Port checker for the dual counter/timer
module dual_timer_sva
	import timer_pkg::*;
(
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// Register port
	input wire logic [7:0] reg_addr,
	input wire logic reg_wr,
	input wire logic [7:0] reg_wdata,
	input wire logic [7:0] reg_rdata,
	// Status
	input wire logic timer_a_vector_ack,
	input wire logic timer_b_vector_ack,
	input wire logic timer_a_overflow_flag,
	input wire logic timer_b_overflow_flag,
	input wire logic timer_b_overflow_pulse
);
	// ----
	// Shadow of run bits and split mode
	// ----
	logic run_a, run_b, split;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			run_a <= 1'b0;
			run_b <= 1'b0;
		end else if (reg_wr && reg_addr == ADDR_TIMER_CONTROL_STATUS) begin
			run_a <= reg_wdata[TCS_A_RUN];
			run_b <= reg_wdata[TCS_B_RUN];
		end
	end
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			split <= 1'b0;
		end else if (reg_wr && reg_addr == ADDR_TIMER_MODE_REG) begin
			split <= reg_wdata[1:0] == 2'h3;
		end
	end
	// ----
	// Properties
	// ----
	// Three idle cycles cover any enable pipeline
	sequence s_a_idle;
		(!run_a) [*3];
	endsequence
	sequence s_b_idle;
		(!run_b) [*3];
	endsequence
	sequence s_ctl_wr;
		reg_wr && reg_addr == ADDR_TIMER_CONTROL_STATUS;
	endsequence
	a_unmapped_zero: assert property (
		reg_addr == 8'h00 |=> reg_rdata == 8'h00)
		else $error("unmapped read nonzero");
	a_ctrl_readback: assert property (
		reg_addr == ADDR_TIMER_CONTROL_STATUS |=> reg_rdata ==
		{$past(timer_b_overflow_flag), $past(run_b),
		$past(timer_a_overflow_flag), $past(run_a), 4'h0})
		else $error("control readback wrong");
	a_ack_clear_a: assert property (
		s_a_idle ##0 timer_a_vector_ack |=> !timer_a_overflow_flag)
		else $error("timer A flag kept after ack");
	a_ack_clear_b: assert property (
		s_b_idle ##0 timer_b_vector_ack |=> !timer_b_overflow_flag)
		else $error("timer B flag kept after ack");
	a_hold_flag_a: assert property (
		s_a_idle ##0 !(timer_a_vector_ack || reg_wr)
		|=> $stable(timer_a_overflow_flag))
		else $error("timer A flag moved while stopped");
	a_hold_flag_b: assert property (
		s_b_idle ##0 !(timer_b_vector_ack || reg_wr)
		|=> $stable(timer_b_overflow_flag))
		else $error("timer B flag moved while stopped");
	a_sw_flag_a: assert property (
		s_a_idle ##0 s_ctl_wr ##0 !timer_a_vector_ack
		|=> timer_a_overflow_flag == $past(reg_wdata[TCS_A_OVERFLOW]))
		else $error("timer A flag ignored write");
	a_pulse_flag_b: assert property (
		timer_b_overflow_pulse && !$past(split) |-> timer_b_overflow_flag)
		else $error("timer B overflow left flag clear");
endmodule // dual_timer_sva

bind dual_timer dual_timer_sva chk (.ref_clk, .rst, .reg_addr, .reg_wr,
	.reg_wdata, .reg_rdata, .timer_a_vector_ack, .timer_b_vector_ack,
	.timer_a_overflow_flag, .timer_b_overflow_flag, .timer_b_overflow_pulse);

// >>> pins_model.sv
// Far-side model of count pins, gate lines and prescale clock
module pins_model (
	// Clock
	input wire logic ref_clk,
	// Pins
	output logic [1:0] count_pin,
	output logic [1:0] gate_line,
	output logic ext_clk
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [1:0] ph = 2'h0;
	// ----
	// Free oscillator, four system cycles a period
	// ----
	initial begin
		count_pin = 2'h3;
		gate_line = 2'h0;
	end
	always @(posedge ref_clk) ph <= ph + 2'h1;
	assign ext_clk = ph[1];
	// Three cycles a level gives slack over the floor
	task automatic pulse(input int t, input int n);
		repeat (n) begin
			repeat (3) @(posedge ref_clk);
			#1 count_pin[t] = 1'b0;
			repeat (3) @(posedge ref_clk);
			#1 count_pin[t] = 1'b1;
		end
	endtask
	task automatic gate(input int t, input logic v);
		gate_line[t] = v;
	endtask
endmodule // pins_model

// >>> prescaler.sv
// Prescaled clock-enable generator for the counter/timers
module prescaler
	import timer_pkg::*;
(
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// Control
	input wire logic [1:0] prescale_field,
	input wire logic ext_clk_edge,
	// Enable out
	output logic tick
);
	logic [5:0] count;
	logic [5:0] limit;
	logic step;

	always_comb begin
		limit = 6'(DIV12 - 1);
		step = 1'b1;
		case (prescale_field)
			SCALE_DIV4: limit = 6'(DIV4 - 1);
			SCALE_DIV48: limit = 6'(DIV48 - 1);
			SCALE_EXT8: begin
				limit = 6'(DIV_EXT - 1);
				step = ext_clk_edge;
			end
			default: limit = 6'(DIV12 - 1);
		endcase
	end

	// ----------------------------------------
	// Divider
	// ----------------------------------------
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			count <= 6'h00;
			tick <= 1'b0;
		end else begin
			tick <= 1'b0;
			if (step) begin
				if (count >= limit) begin
					count <= 6'h00;
					tick <= 1'b1;
				end else begin
					count <= count + 6'h01;
				end
			end
		end
	end
endmodule // prescaler

// >>> timer_pkg.sv
// Constants shared by the dual counter/timer block
package timer_pkg;
	// ----------------------------------------
	// Register addresses
	// ----------------------------------------
	localparam logic [7:0] ADDR_TIMER_CONTROL_STATUS = 8'h88;
	localparam logic [7:0] ADDR_TIMER_MODE_REG = 8'h89;
	localparam logic [7:0] ADDR_TIMER_A_LOW_BYTE = 8'h8A;
	localparam logic [7:0] ADDR_TIMER_B_LOW_BYTE = 8'h8B;
	localparam logic [7:0] ADDR_TIMER_A_HIGH_BYTE = 8'h8C;
	localparam logic [7:0] ADDR_TIMER_B_HIGH_BYTE = 8'h8D;
	localparam logic [7:0] ADDR_CLOCK_CONTROL_REG = 8'h8E;
	localparam logic [7:0] ADDR_EXT_INTERRUPT_CONFIG_REG = 8'hE4;
	// ----------------------------------------
	// Reset values
	// ----------------------------------------
	localparam logic [7:0] RESET_BYTE = 8'h00;
	// ----------------------------------------
	// Control/status bit positions
	// ----------------------------------------
	localparam int TCS_B_OVERFLOW = 7;
	localparam int TCS_B_RUN = 6;
	localparam int TCS_A_OVERFLOW = 5;
	localparam int TCS_A_RUN = 4;
	// Mode register: timer B in upper nibble, timer A in lower
	localparam int MODE_B_LSB = 4;
	localparam int MODE_A_LSB = 0;
	localparam int MODE_GATE = 3;
	localparam int MODE_COUNT_SEL = 2;
	localparam int MODE_FIELD_LSB = 0;
	// Clock control
	localparam int CLK_B_SELECT = 3;
	localparam int CLK_A_SELECT = 2;
	localparam int PRESCALE_LSB = 0;
	// Interrupt config polarity bits
	localparam int FIRST_LINE_POLARITY = 3;
	localparam int SECOND_LINE_POLARITY = 7;
	// ----------------------------------------
	// Modes and prescale
	// ----------------------------------------
	typedef enum logic [1:0] {
		MODE_13BIT,
		MODE_16BIT,
		MODE_RELOAD8,
		MODE_SPLIT
	} timer_mode_e;
	localparam logic [1:0] SCALE_DIV12 = 2'h0;
	localparam logic [1:0] SCALE_DIV4 = 2'h1;
	localparam logic [1:0] SCALE_DIV48 = 2'h2;
	localparam logic [1:0] SCALE_EXT8 = 2'h3;
	localparam int DIV12 = 12;
	localparam int DIV4 = 4;
	localparam int DIV48 = 48;
	localparam int DIV_EXT = 8;
	localparam logic [4:0] LOW5_MAX = 5'h1F;
	localparam logic [7:0] BYTE_MAX = 8'hFF;
endpackage
